/* File: common/adcsc_defines.vh */
// Purpose: constants of the converter sequencing control block
// Assumes: byte-wide register port, 8-bit offsets
// Notes:   included by rtl/adcsc_control.v only
`ifndef ADCSC_DEFINES_VH
`define ADCSC_DEFINES_VH

// register offsets
`define ADCSC_OFS_CONTROL    8'h00
`define ADCSC_OFS_CLKSEL     8'h02
`define ADCSC_OFS_TIMING     8'h03
`define ADCSC_OFS_WINMODE    8'h04
`define ADCSC_OFS_SAMPEXT    8'h05
`define ADCSC_OFS_INSEL      8'h06
`define ADCSC_OFS_CMD        8'h08
`define ADCSC_OFS_EVCTL      8'h09
`define ADCSC_OFS_INTEN      8'h0A
`define ADCSC_OFS_INTFLAG    8'h0B
`define ADCSC_OFS_DBG        8'h0C
`define ADCSC_OFS_RESLO      8'h10
`define ADCSC_OFS_RESHI      8'h11
`define ADCSC_OFS_WLTLO      8'h12
`define ADCSC_OFS_WLTHI      8'h13
`define ADCSC_OFS_WHTLO      8'h14
`define ADCSC_OFS_WHTHI      8'h15

// field positions
`define ADCSC_BIT_ENABLE     0
`define ADCSC_BIT_CONTIN     1
`define ADCSC_BIT_START      0
`define ADCSC_BIT_EVEN       0
`define ADCSC_BIT_READY      0
`define ADCSC_BIT_WINFLAG    1
`define ADCSC_BIT_RUNDBG     0
`define ADCSC_BIT_DLYVAR     4
`define ADCSC_RNG_STARTDLY   7:5
`define ADCSC_RNG_GAPDLY     3:0
`define ADCSC_RNG_DIVSEL     2:0
`define ADCSC_RNG_REFSEL     5:4
`define ADCSC_RNG_WINMODE    2:0
`define ADCSC_RNG_SAMPEXT    4:0
`define ADCSC_RNG_INSEL      4:0

// reset values
`define ADCSC_RST_BYTE       8'h00
`define ADCSC_RST_WORD       16'h0000
`define ADCSC_REF_INTERNAL   2'h0

// window modes
`define ADCSC_WIN_NONE       3'h0
`define ADCSC_WIN_BELOW      3'h1
`define ADCSC_WIN_ABOVE      3'h2
`define ADCSC_WIN_INSIDE     3'h3
`define ADCSC_WIN_OUTSIDE    3'h4

// input selector codes
`define ADCSC_SEL_REFIN      5'h1D
`define ADCSC_SEL_TEMP       5'h1E
`define ADCSC_SEL_GND        5'h1F
`define ADCSC_NUM_PINS       12

// timing, in converter clock cycles
`define ADCSC_SAMPLE_BASE    9'h002
`define ADCSC_INIT_D0        9'h000
`define ADCSC_INIT_D16       9'h010
`define ADCSC_INIT_D32       9'h020
`define ADCSC_INIT_D64       9'h040
`define ADCSC_INIT_D128      9'h080
`define ADCSC_INIT_D256      9'h100
`define ADCSC_DIV_FULL       8'hFF
`define ADCSC_DIV_TOP        3'h7

`endif

/* File: rtl/adcsc_control.v */
// Purpose: sequencing control of a 10-bit successive-approximation converter
// Assumes: one clock clk_sys (100 MHz), synchronous active-high reset,
//          analog core answers each convStart with one convDone pulse
// Notes:   converter clock is a one-cycle enable pulse, adcClkTick
`timescale 1ns/100ps
`include "adcsc_defines.vh"

module adcsc_control (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst,
   // register port
   input  wire [7:0]  regAddr,
   input  wire [7:0]  regWrData,
   input  wire        regWrite,
   input  wire        regRead,
   output wire [7:0]  regRdData,
   // system status
   input  wire        debugHalt,
   input  wire        deepSleepWake,
   input  wire        eventStart,
   // converter core
   output wire        adcClkTick,
   output wire        sampleOpen,
   output wire        convStart,
   output wire        convBusy,
   output wire [4:0]  inputSelActive,
   output wire [11:0] pinSelect,
   output wire        refSelect,
   output wire        tempSelect,
   output wire        gndSelect,
   input  wire        convDone,
   input  wire [15:0] convResult,
   // interrupt
   output wire        irqRequest
);

   localparam [4:0] ST_IDLE    = 5'h01;
   localparam [4:0] ST_INIT    = 5'h02;
   localparam [4:0] ST_DELAY   = 5'h04;
   localparam [4:0] ST_SAMPLE  = 5'h08;
   localparam [4:0] ST_CONVERT = 5'h10;

   // software registers
   reg [7:0]  control_reg;
   reg [7:0]  clkSel_reg;
   reg [7:0]  timing_reg;
   reg [7:0]  winMode_reg;
   reg [7:0]  sampling_extension_reg;
   reg [7:0]  inSel_reg;
   reg [7:0]  evCtl_reg;
   reg [7:0]  intEn_reg;
   reg [7:0]  dbg_reg;
   reg [15:0] winLow_reg;
   reg [15:0] winHigh_reg;
   reg [15:0] result_reg;
   reg        result_ready_reg;
   reg        winFlag_reg;
   reg [7:0]  rdData_reg;
   reg        irq_reg;

   // sequencer state
   reg [4:0]  state_reg;
   reg [8:0]  cnt_reg;
   reg [7:0]  div_reg;
   reg        tick_reg;
   reg        initPend_reg;
   reg        convStart_reg;
   reg        busy_reg;
   reg [4:0]  muxActive_reg;

   wire       enable      = control_reg[`ADCSC_BIT_ENABLE];
   wire       contin      = control_reg[`ADCSC_BIT_CONTIN];
   wire [2:0] divSel      = clkSel_reg[`ADCSC_RNG_DIVSEL];
   wire [2:0] initCode    = timing_reg[`ADCSC_RNG_STARTDLY];
   wire [3:0] inter_sample_delay     = timing_reg[`ADCSC_RNG_GAPDLY];
   wire       dlyVarOn    = timing_reg[`ADCSC_BIT_DLYVAR];
   wire [2:0] winMode     = winMode_reg[`ADCSC_RNG_WINMODE];
   wire [4:0] sampExt     = sampling_extension_reg[`ADCSC_RNG_SAMPEXT];
   wire [4:0] inSel       = inSel_reg[`ADCSC_RNG_INSEL];
   wire       runDbg      = dbg_reg[`ADCSC_BIT_RUNDBG];
   wire       evEnable    = evCtl_reg[`ADCSC_BIT_EVEN];

   // register access decode
   wire wrControl = regWrite && (regAddr == `ADCSC_OFS_CONTROL);
   wire wrClkSel  = regWrite && (regAddr == `ADCSC_OFS_CLKSEL);
   wire wrTiming  = regWrite && (regAddr == `ADCSC_OFS_TIMING);
   wire wrCmd     = regWrite && (regAddr == `ADCSC_OFS_CMD);
   wire wrFlags   = regWrite && (regAddr == `ADCSC_OFS_INTFLAG);
   wire rdResult  = regRead && (regAddr == `ADCSC_OFS_RESLO);

   // debug break freezes sequencing and drops events
   wire runOk     = runDbg | ~debugHalt;
   wire tick      = tick_reg & runOk;
   wire isIdle    = state_reg[0];

   wire swStart   = wrCmd && regWrData[`ADCSC_BIT_START];
   wire evStartOk = eventStart && evEnable;
   wire startReq  = (swStart | evStartOk) && enable && isIdle && runOk;

   // clock divider, power of two from the select field
   wire [7:0] divMask = `ADCSC_DIV_FULL >> (`ADCSC_DIV_TOP - divSel);
   wire       divHit  = (div_reg & divMask) == divMask;

   always @(posedge clk_sys) begin
      if (rst) begin
         div_reg  <= `ADCSC_RST_BYTE;
         tick_reg <= 1'b0;
      end else begin
         div_reg  <= div_reg + 8'h01;
         tick_reg <= divHit;
      end
   end

   // start-up delay lookup, reserved codes give no delay
   reg [8:0] initCount;
   always @* begin
      case (initCode)
         3'h1:    initCount = `ADCSC_INIT_D16;
         3'h2:    initCount = `ADCSC_INIT_D32;
         3'h3:    initCount = `ADCSC_INIT_D64;
         3'h4:    initCount = `ADCSC_INIT_D128;
         3'h5:    initCount = `ADCSC_INIT_D256;
         default: initCount = `ADCSC_INIT_D0;
      endcase
   end

   wire [8:0] sampleCount = `ADCSC_SAMPLE_BASE + {4'h0, sampExt};

   // window compare on the value the core delivers; with accumulation
   // that is already the final sum, never a single sample
   reg winHit;
   always @* begin
      case (winMode)
         `ADCSC_WIN_BELOW:   winHit = convResult < winLow_reg;
         `ADCSC_WIN_ABOVE:   winHit = convResult > winHigh_reg;
         `ADCSC_WIN_INSIDE:  winHit = (convResult > winLow_reg) && (convResult < winHigh_reg);
         `ADCSC_WIN_OUTSIDE: winHit = (convResult < winLow_reg) || (convResult > winHigh_reg);
         default:            winHit = 1'b0;
      endcase
   end

   wire convEnd  = state_reg[4] && convDone;
   wire sampEnd  = state_reg[3] && tick && (cnt_reg == 9'h001);

   // start-up delay pending after enable, internal reference or wake
   wire enRise   = wrControl && regWrData[`ADCSC_BIT_ENABLE] && !enable;
   wire refToInt = wrClkSel && (regWrData[`ADCSC_RNG_REFSEL] == `ADCSC_REF_INTERNAL)
                   && (clkSel_reg[`ADCSC_RNG_REFSEL] != `ADCSC_REF_INTERNAL);

   always @(posedge clk_sys) begin
      if (rst) begin
         initPend_reg <= 1'b0;
      end else if (enRise || refToInt || deepSleepWake) begin
         initPend_reg <= 1'b1;
      end else if (startReq) begin
         initPend_reg <= 1'b0;
      end
   end

   // sequencer
   always @(posedge clk_sys) begin
      if (rst) begin
         state_reg     <= ST_IDLE;
         cnt_reg       <= `ADCSC_INIT_D0;
         busy_reg      <= 1'b0;
         convStart_reg <= 1'b0;
         muxActive_reg <= 5'h00;
      end else begin
         convStart_reg <= 1'b0;
         if (!enable && !isIdle) begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  if (startReq) begin
                     busy_reg      <= 1'b1;
                     muxActive_reg <= inSel;
                     if (initPend_reg) begin
                        state_reg <= ST_INIT;
                        cnt_reg   <= initCount;
                     end else begin
                        state_reg <= ST_SAMPLE;
                        cnt_reg   <= sampleCount;
                     end
                  end
               end
               ST_INIT, ST_DELAY: begin
                  if (runOk && cnt_reg == `ADCSC_INIT_D0) begin
                     state_reg <= ST_SAMPLE;
                     cnt_reg   <= sampleCount;
                  end else if (tick) begin
                     cnt_reg <= cnt_reg - 9'h001;
                  end
               end
               ST_SAMPLE: begin
                  if (sampEnd) begin
                     state_reg     <= ST_CONVERT;
                     convStart_reg <= 1'b1;
                  end else if (tick) begin
                     cnt_reg <= cnt_reg - 9'h001;
                  end
               end
               ST_CONVERT: begin
                  if (convDone) begin
                     if (contin) begin
                        // next cycle picks up any new selector
                        state_reg     <= ST_DELAY;
                        cnt_reg       <= {5'h00, inter_sample_delay};
                        muxActive_reg <= inSel;
                     end else begin
                        state_reg <= ST_IDLE;
                        busy_reg  <= 1'b0;
                     end
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
                  busy_reg  <= 1'b0;
               end
            endcase
         end
      end
   end

   // flags and result; a set in the clearing cycle wins
   wire clrRes  = rdResult || (wrFlags && regWrData[`ADCSC_BIT_READY]);
   wire clrWin  = rdResult || (wrFlags && regWrData[`ADCSC_BIT_WINFLAG]);

   always @(posedge clk_sys) begin
      if (rst) begin
         result_reg  <= `ADCSC_RST_WORD;
         result_ready_reg  <= 1'b0;
         winFlag_reg <= 1'b0;
      end else begin
         if (convEnd) begin
            result_reg <= convResult;
         end
         if (convEnd) begin
            result_ready_reg <= 1'b1;
         end else if (clrRes) begin
            result_ready_reg <= 1'b0;
         end
         if (convEnd && winHit) begin
            winFlag_reg <= 1'b1;
         end else if (clrWin) begin
            winFlag_reg <= 1'b0;
         end
      end
   end

   // software registers, sample delay also stepped by hardware
   always @(posedge clk_sys) begin
      if (rst) begin
         control_reg <= `ADCSC_RST_BYTE;
         clkSel_reg  <= `ADCSC_RST_BYTE;
         timing_reg  <= `ADCSC_RST_BYTE;
         winMode_reg <= `ADCSC_RST_BYTE;
         sampling_extension_reg <= `ADCSC_RST_BYTE;
         inSel_reg   <= `ADCSC_RST_BYTE;
         evCtl_reg   <= `ADCSC_RST_BYTE;
         intEn_reg   <= `ADCSC_RST_BYTE;
         dbg_reg     <= `ADCSC_RST_BYTE;
         winLow_reg  <= `ADCSC_RST_WORD;
         winHigh_reg <= `ADCSC_RST_WORD;
      end else begin
         if (wrControl) begin
            control_reg <= regWrData;
         end
         if (wrClkSel) begin
            clkSel_reg <= regWrData;
         end
         if (wrTiming) begin
            timing_reg <= regWrData;
         end else if (sampEnd && dlyVarOn) begin
            // four-bit field wraps from its top back to zero
            timing_reg[`ADCSC_RNG_GAPDLY] <= inter_sample_delay + 4'h1;
         end
         if (regWrite) begin
            case (regAddr)
               `ADCSC_OFS_WINMODE: winMode_reg <= regWrData;
               `ADCSC_OFS_SAMPEXT: sampling_extension_reg <= regWrData;
               `ADCSC_OFS_INSEL:   inSel_reg <= regWrData;
               `ADCSC_OFS_EVCTL:   evCtl_reg <= regWrData;
               `ADCSC_OFS_INTEN:   intEn_reg <= regWrData;
               `ADCSC_OFS_DBG:     dbg_reg <= regWrData;
               `ADCSC_OFS_WLTLO:   winLow_reg[7:0] <= regWrData;
               `ADCSC_OFS_WLTHI:   winLow_reg[15:8] <= regWrData;
               `ADCSC_OFS_WHTLO:   winHigh_reg[7:0] <= regWrData;
               `ADCSC_OFS_WHTHI:   winHigh_reg[15:8] <= regWrData;
               default: begin
               end
            endcase
         end
      end
   end

   // read mux, unmapped offsets read zero
   reg [7:0] rdMux;
   always @* begin
      case (regAddr)
         `ADCSC_OFS_CONTROL: rdMux = control_reg;
         `ADCSC_OFS_CLKSEL:  rdMux = clkSel_reg;
         `ADCSC_OFS_TIMING:  rdMux = timing_reg;
         `ADCSC_OFS_WINMODE: rdMux = winMode_reg;
         `ADCSC_OFS_SAMPEXT: rdMux = sampling_extension_reg;
         `ADCSC_OFS_INSEL:   rdMux = inSel_reg;
         `ADCSC_OFS_CMD:     rdMux = {7'h00, busy_reg};
         `ADCSC_OFS_EVCTL:   rdMux = evCtl_reg;
         `ADCSC_OFS_INTEN:   rdMux = intEn_reg;
         `ADCSC_OFS_INTFLAG: rdMux = {6'h00, winFlag_reg, result_ready_reg};
         `ADCSC_OFS_DBG:     rdMux = dbg_reg;
         `ADCSC_OFS_RESLO:   rdMux = result_reg[7:0];
         `ADCSC_OFS_RESHI:   rdMux = result_reg[15:8];
         `ADCSC_OFS_WLTLO:   rdMux = winLow_reg[7:0];
         `ADCSC_OFS_WLTHI:   rdMux = winLow_reg[15:8];
         `ADCSC_OFS_WHTLO:   rdMux = winHigh_reg[7:0];
         `ADCSC_OFS_WHTHI:   rdMux = winHigh_reg[15:8];
         default:            rdMux = `ADCSC_RST_BYTE;
      endcase
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         rdData_reg <= `ADCSC_RST_BYTE;
         irq_reg    <= 1'b0;
      end else begin
         rdData_reg <= regRead ? rdMux : `ADCSC_RST_BYTE;
         irq_reg    <= (result_ready_reg & intEn_reg[`ADCSC_BIT_READY])
                     | (winFlag_reg & intEn_reg[`ADCSC_BIT_WINFLAG]);
      end
   end

   // input decode from the selector latched when a start is accepted, or at convDone in continuous mode
   genvar gi;
   generate
      for (gi = 0; gi < `ADCSC_NUM_PINS; gi = gi + 1) begin : gPin
         assign pinSelect[gi] = (muxActive_reg == gi);
      end
   endgenerate

   assign refSelect      = (muxActive_reg == `ADCSC_SEL_REFIN);
   assign tempSelect     = (muxActive_reg == `ADCSC_SEL_TEMP);
   assign gndSelect      = (muxActive_reg == `ADCSC_SEL_GND);
   assign inputSelActive = muxActive_reg;
   // capacitor open in the sample state only, closed through the inter-sample delay
   assign sampleOpen     = state_reg[3];
   assign convStart      = convStart_reg;
   assign convBusy       = busy_reg;
   assign adcClkTick     = tick_reg;
   assign regRdData      = rdData_reg;
   assign irqRequest     = irq_reg;

endmodule

/* File: tb/adcsc_control_assertions.sv */
// Purpose: concurrent checks on the ports of adcsc_control
// Assumes: one clock domain, synchronous active-high rst
// Notes:   enables are snooped from the write port, as the fields update
`timescale 1ns/100ps
module adcsc_control_chk (
   // clock and reset
   input wire        clk_sys, rst,
   // register port
   input wire [7:0]  regAddr, regWrData, regRdData,
   input wire        regWrite, regRead,
   // system status
   input wire        debugHalt, deepSleepWake, eventStart,
   // converter core
   input wire        adcClkTick, sampleOpen, convStart, convBusy, convDone,
   input wire        refSelect, tempSelect, gndSelect,
   input wire [4:0]  inputSelActive,
   input wire [11:0] pinSelect,
   input wire [15:0] convResult,
   // interrupt
   input wire        irqRequest
);
   reg [1:0] ctlReg, ienReg;
   reg       dbgReg, inConvReg;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // convert phase tracked here since convDone only counts inside it
   always @(posedge clk_sys) begin
      if (rst) begin
         ctlReg <= 2'h0;
         ienReg <= 2'h0;
         dbgReg <= 1'h0;
         inConvReg <= 1'h0;
      end else begin
         if (regWrite && regAddr == 8'h00) ctlReg <= regWrData[1:0];
         if (regWrite && regAddr == 8'h0A) ienReg <= regWrData[1:0];
         if (regWrite && regAddr == 8'h0C) dbgReg <= regWrData[0];
         if (convStart) inConvReg <= 1'h1;
         else if (convDone || !convBusy) inConvReg <= 1'h0;
      end
   end
   chk_tick_gap:
      assert property (adcClkTick |=> !adcClkTick) else $error("converter tick two cycles long");
   chk_sel_decode:
      assert property (pinSelect == ((inputSelActive < 5'h0C) ? 12'h001 << inputSelActive : 12'h000)
         && {refSelect, tempSelect, gndSelect} == {inputSelActive == 5'h1D, inputSelActive == 5'h1E,
         inputSelActive == 5'h1F}) else $error("input decode wrong");
   chk_sel_hold:
      assert property (inConvReg && $past(inConvReg) |-> $stable(inputSelActive))
         else $error("selector moved during conversion");
   chk_sample_end:
      assert property ($fell(sampleOpen) && convBusy |-> convStart && $past(adcClkTick))
         else $error("sampling ended off a tick");
   chk_start_busy:
      assert property (regWrite && regAddr == 8'h08 && regWrData[0] && ctlReg[0] && !convBusy
         && !(debugHalt && !dbgReg) |=> convBusy) else $error("start write ignored");
   chk_busy_clear:
      assert property (inConvReg && convDone && !ctlReg[1] |=> !convBusy) else $error("busy after single");
   chk_free_run:
      assert property (inConvReg && convDone && ctlReg == 2'h3 && !regWrite |=> convBusy)
         else $error("continuous run stopped");
   chk_ready_irq:
      assert property (inConvReg && convDone && ienReg[0] |-> ##2 irqRequest) else $error("no ready irq");
   chk_irq_mask:
      assert property (ienReg == 2'h0 && $past(ienReg) == 2'h0 |-> !irqRequest) else $error("irq while masked");
   chk_halt_drop:
      assert property (debugHalt && !dbgReg && !convBusy |=> !convBusy) else $error("start while halted");
   chk_flag_clear:
      assert property (((regRead && regAddr == 8'h10) || (regWrite && regAddr == 8'h0B && regWrData[1:0] == 2'h3))
         && !convDone |-> ##2 !irqRequest) else $error("flags not cleared");
endmodule
bind adcsc_control adcsc_control_chk i_chk (.clk_sys, .rst, .regAddr, .regWrData, .regRdData, .regWrite,
   .regRead, .debugHalt, .deepSleepWake, .eventStart, .adcClkTick, .sampleOpen, .convStart, .convBusy,
   .convDone, .refSelect, .tempSelect, .gndSelect, .inputSelActive, .pinSelect, .convResult, .irqRequest);

/* File: tb/tb.sv */
// Purpose: self-checking bench for adcsc_control
// Assumes: bench plays the converter core, answering convStart after 20 cycles
// Notes:   divider kept at 0 after its own test to keep runs short
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
   // clock, reset, register port
   logic        clk_sys = 1'h0, rst = 1'h1, regWrite = 1'h0, regRead = 1'h0;
   logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, d;
   wire  [7:0]  regRdData;
   // status inputs and core side
   logic        debugHalt = 1'h0, deepSleepWake = 1'h0, eventStart = 1'h0, convDone = 1'h0;
   logic [15:0] convResult = 16'h0000;
   wire         adcClkTick, sampleOpen, convStart, convBusy, refSelect, tempSelect, gndSelect, irqRequest;
   wire  [4:0]  inputSelActive;
   wire  [11:0] pinSelect;
   int          miscompares = 0, n_tests = 0, cycles = 0, coreCnt = 0, n, i, k;
   // {address, value}; 0x07 is unmapped
   logic [15:0] rwTab[8] = '{16'h03A3, 16'h0403, 16'h051F, 16'h061D, 16'h0901, 16'h0A03, 16'h0C01, 16'h07FF};
   logic [7:0]  selTab[4] = '{8'h0B, 8'h1D, 8'h1E, 8'h1F};
   // {expected window flag, mode, result} against low 0x0100, high 0x0200
   logic [19:0] wTab[11] = '{20'h900FF, 20'h10100, 20'hA0201, 20'h20200, 20'hB0150, 20'h30100,
                             20'hC0050, 20'h40150, 20'hC0201, 20'h00050, 20'h50050};
   adcsc_control i_dut (.clk_sys, .rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .debugHalt,
      .deepSleepWake, .eventStart, .adcClkTick, .sampleOpen, .convStart, .convBusy, .inputSelActive,
      .pinSelect, .refSelect, .tempSelect, .gndSelect, .convDone, .convResult, .irqRequest);
   initial forever #5 clk_sys = ~clk_sys;
   // core model and hang limit
   always @(posedge clk_sys) begin
      convDone <= (coreCnt == 1);
      if (convStart === 1'h1) coreCnt <= 20;
      else if (coreCnt != 0) coreCnt <= coreCnt - 1;
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         miscompares++;
         conclude;
      end
   end
   task step; @(posedge clk_sys); #1; endtask
   task wr(input logic [7:0] a, v);
      @(posedge clk_sys);
      regWrite <= 1'h1;
      regAddr <= a;
      regWrData <= v;
      @(posedge clk_sys);
      regWrite <= 1'h0;
      #1;
   endtask
   task chkRd(input logic [7:0] a, e);
      @(posedge clk_sys);
      regRead <= 1'h1;
      regAddr <= a;
      @(posedge clk_sys);
      regRead <= 1'h0;
      #1 d = regRdData;
      `CHK("register", e, d)
   endtask
   task waitIdle;
      for (i = 0; i < 3000 && convBusy !== 1'h0; i++) step;
   endtask
   // counts converter ticks while sampleOpen stays at lvl; at level 0 a tick
   // in the last cycle is never used by the sequencer, so it is skipped
   task cnt(input logic lvl, output int c);
      logic t;
      c = 0;
      for (i = 0; i < 3000 && sampleOpen === lvl; i++) begin
         t = adcClkTick;
         step;
         if (t === 1'h1 && (lvl || sampleOpen === lvl)) c++;
      end
   endtask
   task conv(input logic [15:0] r);
      @(posedge clk_sys) convResult <= r;
      wr(8'h08, 8'h01);
      waitIdle;
   endtask
   task pulseEv;
      @(posedge clk_sys) eventStart <= 1'h1;
      @(posedge clk_sys) eventStart <= 1'h0;
      #1;
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'h0;
      #1;
      for (k = 3; k < 14; k++) chkRd(k[7:0], 8'h00);
      for (k = 0; k < 8; k++) begin
         wr(rwTab[k][15:8], rwTab[k][7:0]);
         chkRd(rwTab[k][15:8], (k == 7) ? 8'h00 : rwTab[k][7:0]);
         wr(rwTab[k][15:8], 8'h00);
      end
      $display("test registers done");
      for (k = 0; k < 8; k++) begin
         wr(8'h02, k[7:0]);
         // skip the tick launched with the old divider setting
         step;
         for (i = 0; i < 600 && adcClkTick !== 1'h1; i++) step;
         n = 0;
         do begin step; n++; end while (adcClkTick !== 1'h1 && n < 600);
         `CHK("divide", 1 << (k + 1), n)
      end
      wr(8'h02, 8'h00);
      wr(8'h00, 8'h01);
      for (k = 0; k < 32; k += 10) begin
         wr(8'h05, k[7:0]);
         wr(8'h08, 8'h01);
         cnt(1'h0, n);
         `CHK("no startup", 0, n)
         cnt(1'h1, n);
         `CHK("sampling", k + 2, n)
         waitIdle;
      end
      wr(8'h05, 8'h00);
      for (k = 0; k < 4; k++) begin
         wr(8'h06, selTab[k]);
         wr(8'h08, 8'h01);
         for (i = 0; i < 300 && convStart !== 1'h1; i++) step;
         wr(8'h06, 8'h00);
         chkRd(8'h08, 8'h01);
         `CHK("selector", selTab[k][4:0], inputSelActive)
         `CHK("decode", {(k == 0) ? 12'h800 : 12'h000, k == 1, k == 2, k == 3},
            {pinSelect, refSelect, tempSelect, gndSelect})
         waitIdle;
         chkRd(8'h08, 8'h00);
      end
      $display("test timing done");
      wr(8'h13, 8'h01);
      wr(8'h15, 8'h02);
      for (k = 0; k < 11; k++) begin
         wr(8'h04, {5'h00, wTab[k][18:16]});
         conv(wTab[k][15:0]);
         chkRd(8'h11, wTab[k][15:8]);
         wr(8'h0B, 8'h00);
         chkRd(8'h0B, {6'h00, wTab[k][19], 1'h1});
         if (k % 2) chkRd(8'h10, wTab[k][7:0]);
         else wr(8'h0B, 8'h03);
         chkRd(8'h0B, 8'h00);
      end
      wr(8'h04, 8'h02);
      wr(8'h0A, 8'h02);
      conv(16'h0300);
      repeat (2) step;
      `CHK("irq window", 1'h1, irqRequest)
      wr(8'h04, 8'h00);
      wr(8'h0B, 8'h03);
      conv(16'h0300);
      repeat (2) step;
      `CHK("irq masked", 1'h0, irqRequest)
      wr(8'h0A, 8'h01);
      repeat (2) step;
      `CHK("irq ready", 1'h1, irqRequest)
      wr(8'h0B, 8'h01);
      repeat (2) step;
      `CHK("irq cleared", 1'h0, irqRequest)
      conv(16'h0300);
      wr(8'h0A, 8'h00);
      $display("test window done");
      wr(8'h09, 8'h01);
      pulseEv;
      `CHK("event start", 1'h1, convBusy)
      waitIdle;
      @(posedge clk_sys) debugHalt <= 1'h1;
      pulseEv;
      `CHK("halted event", 1'h0, convBusy)
      wr(8'h08, 8'h01);
      `CHK("halted start", 1'h0, convBusy)
      wr(8'h0C, 8'h01);
      pulseEv;
      `CHK("debug run", 1'h1, convBusy)
      waitIdle;
      wr(8'h09, 8'h00);
      pulseEv;
      `CHK("event off", 1'h0, convBusy)
      @(posedge clk_sys) debugHalt <= 1'h0;
      wr(8'h0C, 8'h00);
      $display("test triggers done");
      wr(8'h00, 8'h00);
      wr(8'h03, 8'h20);
      wr(8'h00, 8'h01);
      for (k = 0; k < 4; k++) begin
         if (k == 1) @(posedge clk_sys) deepSleepWake <= 1'h1;
         if (k == 1) @(posedge clk_sys) deepSleepWake <= 1'h0;
         // leave the internal reference and come back to it
         if (k == 3) wr(8'h02, 8'h10);
         if (k == 3) wr(8'h02, 8'h00);
         wr(8'h08, 8'h01);
         cnt(1'h0, n);
         `CHK("startup", (k != 2) ? 16 : 0, n)
         waitIdle;
      end
      wr(8'h03, 8'h03);
      wr(8'h00, 8'h03);
      wr(8'h08, 8'h01);
      for (i = 0; i < 300 && convDone !== 1'h1; i++) step;
      step;
      cnt(1'h0, n);
      `CHK("sample gap", 3, n)
      `CHK("free run", 1'h1, convBusy)
      wr(8'h00, 8'h00);
      waitIdle;
      wr(8'h03, 8'h1F);
      wr(8'h00, 8'h01);
      for (k = 0; k < 2; k++) begin
         conv(16'h0000);
         chkRd(8'h03, k ? 8'h11 : 8'h10);
      end
      $display("test sequencing done");
      conclude;
   end
endmodule
